// file: rtl/ocf_top.sv
`timescale 1ns/1ps
`default_nettype none
module ocf_top (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire ocf_pkg::ocf_cmd_s i_cmd,
  input wire logic i_clear_faults,
  input wire logic i_nvm_restore,
  input wire logic [2:0] i_num_phases,
  input wire logic i_oc_fault,
  input wire logic i_pwm_tick,
  input wire logic [23:0] i_rise_cycles,
  input wire logic i_on_cmd,
  input wire logic i_startup_ok,
  input wire logic [31:0] i_phase_current,
  input wire logic signed [15:0] i_die_temp,
  output logic [15:0] o_rd_data,
  output logic o_rd_valid,
  output ocf_pkg::ocf_status_s o_status,
  output logic o_alert,
  output logic [3:0] o_phase_warn,
  output logic o_ot_fault,
  output logic o_power_en,
  output logic o_latched_off
);
  import ocf_pkg::*;

  logic [7:0] action_reg;
  logic [15:0] warn_reg [NUM_PHASE];
  logic [10:0] warn_near_reg [NUM_PHASE];
  logic [7:0] warn_thr_reg [NUM_PHASE];
  logic [15:0] ot_reg;
  logic [15:0] ot_thr_reg;
  logic [3:0] warn_prev_reg;
  logic [15:0] cv_floor;
  logic [15:0] cv_ceil;
  logic [15:0] cv_near;
  logic cv_neg;
  logic cv_ovf;
  logic [1:0] exp_adj;
  logic [2:0] nph;
  logic all_sel;
  logic wr_warn;
  logic wr_ot;
  logic warn_bad;
  logic ot_bad;
  logic [15:0] share_ceil;
  logic [15:0] share_near;
  logic [15:0] stack_max;
  logic [15:0] step_q;
  logic [7:0] thr_next;
  logic [3:0] warn_now;
  logic warn_event;
  logic oc_event;
  logic invalid_event;
  logic [1:0] sel_idx;
  logic [15:0] rd_next;
  logic [15:0] phase0_times;

  // ----------------------------------------
  // write decode and linear conversion
  // ----------------------------------------
  always_comb
  begin
    nph = (i_num_phases == 3'd0) ? 3'd1 : i_num_phases;
    all_sel = (i_cmd.phase == PHASE_ALL);
    sel_idx = i_cmd.phase[1:0];
    wr_warn = i_cmd.wr && (i_cmd.code == CMD_OC_WARN);
    wr_ot = i_cmd.wr && (i_cmd.code == CMD_OT_LIMIT);
    exp_adj = (i_cmd.code == CMD_OT_LIMIT) ? 2'd0 : QUARTER_SHIFT;
  end

  ocf_lin_conv u_conv (
    .i_word(i_cmd.data),
    .i_exp_adj(exp_adj),
    .o_floor(cv_floor),
    .o_ceil(cv_ceil),
    .o_near(cv_near),
    .o_neg(cv_neg),
    .o_ovf(cv_ovf)
  );

  // ----------------------------------------
  // limit checks and per-phase share
  // ----------------------------------------
  always_comb
  begin
    stack_max = PHASE_MAX_Q * {13'h0000, nph};
    // division spreads an all-phase write over the stack
    share_ceil = all_sel ? (cv_ceil + {13'h0000, nph} - 16'h0001) / {13'h0000, nph} : cv_ceil;
    share_near = all_sel ? (cv_near + {14'h0000, nph[2:1]}) / {13'h0000, nph} : cv_near;
    warn_bad = cv_neg || cv_ovf || (all_sel ? (cv_ceil > stack_max) : (cv_ceil > PHASE_MAX_Q)) ||
      (!all_sel && (i_cmd.phase >= 8'(NUM_PHASE)));
    ot_bad = cv_neg || cv_ovf;
    // round up to the next 2 A step, floor at 8 A
    step_q = ((share_ceil + THR_STEP_Q - 16'h0001) / THR_STEP_Q) * THR_STEP_Q;
    thr_next = (step_q < THR_MIN_Q) ? THR_MIN_Q[7:0] : step_q[7:0];
  end

  // ----------------------------------------
  // response byte
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      action_reg <= OC_ACTION_RST;
    else if (i_cmd.wr && i_cmd.code == CMD_OC_ACTION)
      action_reg <= i_cmd.data[7:0];
  end

  // ----------------------------------------
  // per-phase warning limits
  // ----------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PHASE; gp = gp + 1)
    begin : g_phase
      always_ff @(posedge i_clk)
      begin
        if (i_sys_rst)
        begin
          warn_reg[gp] <= {WARN_EXP_RST, WARN_MANT_RST};
          warn_near_reg[gp] <= WARN_MANT_RST;
          warn_thr_reg[gp] <= WARN_MANT_RST[7:0];
        end
        else if (wr_warn && !warn_bad && (all_sel || sel_idx == 2'(gp)))
        begin
          // all-phase writes store the divided share in quarter amperes
          warn_reg[gp] <= all_sel ? {WARN_EXP_RST, share_near[10:0]} : i_cmd.data;
          warn_near_reg[gp] <= share_near[10:0];
          warn_thr_reg[gp] <= thr_next;
        end
        else if (i_nvm_restore)
          warn_reg[gp] <= {WARN_EXP_RST, warn_near_reg[gp]};
      end

      // each phase compares its own current
      assign warn_now[gp] = i_phase_current[gp*8 +: 8] >= warn_thr_reg[gp];
    end
  endgenerate

  // ----------------------------------------
  // overtemperature limit
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ot_reg <= {OT_EXP_RST, OT_MANT_RST};
      ot_thr_reg <= {5'h00, OT_MANT_RST};
    end
    else if (wr_ot && !ot_bad)
    begin
      ot_reg <= i_cmd.data;
      ot_thr_reg <= cv_ceil;
    end
  end

  // ----------------------------------------
  // fault response sequencer
  // ----------------------------------------
  ocf_retry_seq u_seq (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_action(action_reg),
    .i_oc_fault(i_oc_fault),
    .i_pwm_tick(i_pwm_tick),
    .i_rise_cycles(i_rise_cycles),
    .i_on_cmd(i_on_cmd),
    .i_startup_ok(i_startup_ok),
    .o_fault_event(oc_event),
    .o_power_en(o_power_en),
    .o_latched(o_latched_off)
  );

  // ----------------------------------------
  // events
  // ----------------------------------------
  always_comb
  begin
    warn_event = |(warn_now & ~warn_prev_reg);
    invalid_event = (wr_warn && warn_bad) || (wr_ot && ot_bad);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      warn_prev_reg <= 4'h0;
      o_phase_warn <= 4'h0;
    end
    else
    begin
      warn_prev_reg <= warn_now;
      o_phase_warn <= warn_now;
    end
  end

  // ----------------------------------------
  // sticky status, set beats clear
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_status <= '0;
    else
    begin
      o_status.byte_iout_oc <= oc_event || (o_status.byte_iout_oc && !i_clear_faults);
      o_status.iout_ocf <= oc_event || (o_status.iout_ocf && !i_clear_faults);
      o_status.word_iout <= oc_event || warn_event || (o_status.word_iout && !i_clear_faults);
      o_status.byte_none_above <= warn_event || invalid_event ||
        (o_status.byte_none_above && !i_clear_faults);
      o_status.iout_ocw <= warn_event || (o_status.iout_ocw && !i_clear_faults);
      o_status.cml_invalid <= invalid_event || (o_status.cml_invalid && !i_clear_faults);
    end
  end

  // host notification follows any pending flag
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_alert <= 1'b0;
    else
      o_alert <= oc_event || warn_event || invalid_event ||
        ((|o_status) && !i_clear_faults);
  end

  // ----------------------------------------
  // overtemperature detection
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_ot_fault <= 1'b0;
    else
      o_ot_fault <= (ot_thr_reg != OT_DISABLE_C) && !i_die_temp[15] &&
        (i_die_temp >= $signed(ot_thr_reg));
  end

  // ----------------------------------------
  // read back
  // ----------------------------------------
  always_comb
  begin
    phase0_times = {WARN_EXP_RST, 11'(warn_near_reg[0] * {8'h00, nph})};
    case (i_cmd.code)
      CMD_OC_ACTION:
        rd_next = {8'h00, action_reg};
      CMD_OC_WARN:
        rd_next = all_sel ? phase0_times : warn_reg[sel_idx];
      CMD_OT_LIMIT:
        rd_next = ot_reg;
      default:
        rd_next = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_rd_data <= 16'h0000;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_cmd.rd;
      if (i_cmd.rd)
        o_rd_data <= rd_next;
    end
  end

endmodule : ocf_top
`default_nettype wire

// file: common/ocf_pkg.sv
package ocf_pkg;

  // ----------------------------------------
  // command codes and field layout
  // ----------------------------------------
  localparam logic [7:0] CMD_OC_ACTION = 8'h47;
  localparam logic [7:0] CMD_OC_WARN = 8'h4A;
  localparam logic [7:0] CMD_OT_LIMIT = 8'h4F;
  localparam logic [7:0] PHASE_ALL = 8'hFF;
  localparam int NUM_PHASE = 4;
  localparam int ACT_MSB = 7;
  localparam int ACT_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DLY_MSB = 2;
  localparam int DLY_LSB = 0;
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;
  localparam int MANT_MSB = 10;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] OC_ACTION_RST = 8'hF8;
  localparam logic [4:0] WARN_EXP_RST = 5'h1E;
  localparam logic [10:0] WARN_MANT_RST = 11'h0A0;
  localparam logic [4:0] OT_EXP_RST = 5'h00;
  localparam logic [10:0] OT_MANT_RST = 11'h07D;

  // ----------------------------------------
  // codes and counts
  // ----------------------------------------
  localparam logic [1:0] ACT_DELAYED = 2'b10;
  localparam logic [1:0] ACT_IMMEDIATE = 2'b11;
  localparam logic [2:0] RETRY_NONE = 3'd0;
  localparam logic [2:0] RETRY_FOREVER = 3'd7;
  localparam logic [2:0] DLY_TICKS_SHORT = 3'd1;
  localparam logic [2:0] DLY_TICKS_MID = 3'd3;
  localparam logic [2:0] DLY_TICKS_LONG = 3'd7;
  localparam logic [2:0] DLY_CODE_MID = 3'd2;
  localparam logic [2:0] DLY_CODE_LONG = 3'd5;
  localparam logic [1:0] QUARTER_SHIFT = 2'd2;
  localparam logic [15:0] PHASE_MAX_Q = 16'h00F8;
  localparam logic [15:0] THR_MIN_Q = 16'h0020;
  localparam logic [15:0] THR_STEP_Q = 16'h0008;
  localparam logic [15:0] OT_DISABLE_C = 16'h00FF;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_START,
    SEQ_RUN,
    SEQ_DELAY,
    SEQ_WAIT,
    SEQ_LATCH
  } ocf_seq_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [7:0] phase;
    logic [15:0] data;
  } ocf_cmd_s;

  typedef struct packed {
    logic byte_iout_oc;
    logic byte_none_above;
    logic word_iout;
    logic iout_ocf;
    logic iout_ocw;
    logic cml_invalid;
  } ocf_status_s;

endpackage : ocf_pkg

// file: rtl/ocf_lin_conv.sv
`timescale 1ns/1ps
`default_nettype none
module ocf_lin_conv (
  input wire logic [15:0] i_word,
  input wire logic [1:0] i_exp_adj,
  output logic [15:0] o_floor,
  output logic [15:0] o_ceil,
  output logic [15:0] o_near,
  output logic o_neg,
  output logic o_ovf
);
  import ocf_pkg::*;

  logic signed [5:0] shift;
  logic [4:0] rsh;
  logic [15:0] mag;
  logic [15:0] mask;
  logic frac;
  logic half;

  // ----------------------------------------
  // linear word to scaled integer
  // ----------------------------------------
  always_comb
  begin
    shift = $signed({i_word[EXP_MSB], i_word[EXP_MSB:EXP_LSB]}) + $signed({4'h0, i_exp_adj});
    mag = {6'h00, i_word[MANT_MSB-1:0]};
    o_neg = i_word[MANT_MSB];
    rsh = 5'h00;
    mask = 16'h0000;
    frac = 1'b0;
    half = 1'b0;
    o_ovf = 1'b0;
    if (shift >= 0)
    begin
      // a mantissa of ten bits fits shifted by up to six
      o_ovf = (shift > 6) && (mag != 16'h0000);
      o_floor = mag << shift[2:0];
    end
    else
    begin
      rsh = 5'(-shift);
      mask = (16'h0001 << rsh) - 16'h0001;
      frac = |(mag & mask);
      half = (rsh != 5'h00) && (((mag >> (rsh - 5'h01)) & 16'h0001) != 16'h0000);
      o_floor = mag >> rsh;
    end
    o_ceil = o_floor + {15'h0000, frac};
    o_near = o_floor + {15'h0000, half};
  end

endmodule : ocf_lin_conv
`default_nettype wire

// file: rtl/ocf_retry_seq.sv
`timescale 1ns/1ps
`default_nettype none
module ocf_retry_seq (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_action,
  input wire logic i_oc_fault,
  input wire logic i_pwm_tick,
  input wire logic [23:0] i_rise_cycles,
  input wire logic i_on_cmd,
  input wire logic i_startup_ok,
  output logic o_fault_event,
  output logic o_power_en,
  output logic o_latched
);
  import ocf_pkg::*;

  ocf_seq_e state_reg;
  logic [2:0] tries_reg;
  logic [2:0] tick_reg;
  logic [23:0] rise_reg;
  logic [2:0] mult_reg;
  logic prev_fault_reg;
  logic [1:0] act;
  logic [2:0] retry;
  logic [2:0] dsel;
  logic [2:0] dly_ticks;
  logic [2:0] restart_wait_period_mult;
  logic fault_rise;
  logic give_up;
  logic rise_done;

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  always_comb
  begin
    act = i_action[ACT_MSB:ACT_LSB];
    retry = i_action[RETRY_MSB:RETRY_LSB];
    dsel = i_action[DLY_MSB:DLY_LSB];
    fault_rise = i_oc_fault && !prev_fault_reg;
    // delay in switching cycles and restart_wait_period multiple
    if (dsel >= DLY_CODE_LONG)
      dly_ticks = DLY_TICKS_LONG;
    else if (dsel >= DLY_CODE_MID)
      dly_ticks = DLY_TICKS_MID;
    else
      dly_ticks = DLY_TICKS_SHORT;
    restart_wait_period_mult = (dsel < DLY_CODE_MID) ? 3'd1 : dsel;
    give_up = (retry == RETRY_NONE) || ((retry != RETRY_FOREVER) && (tries_reg >= retry));
    rise_done = (rise_reg + 24'h000001 >= i_rise_cycles);
  end

  // ----------------------------------------
  // edge memory of the comparator
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      prev_fault_reg <= 1'b0;
    else
      prev_fault_reg <= i_oc_fault;
  end

  // ----------------------------------------
  // fault response state machine
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_reg <= SEQ_IDLE;
      tries_reg <= 3'd0;
      tick_reg <= 3'd0;
      rise_reg <= 24'h000000;
      mult_reg <= 3'd0;
    end
    else if (!i_on_cmd)
    begin
      state_reg <= SEQ_IDLE;
      tries_reg <= 3'd0;
    end
    else
    begin
      case (state_reg)
        SEQ_IDLE:
          state_reg <= SEQ_START;
        SEQ_START, SEQ_RUN:
        begin
          if (i_startup_ok)
          begin
            tries_reg <= 3'd0;
            state_reg <= SEQ_RUN;
          end
          if (i_oc_fault && act == ACT_IMMEDIATE)
          begin
            state_reg <= give_up ? SEQ_LATCH : SEQ_WAIT;
            rise_reg <= 24'h000000;
            mult_reg <= 3'd0;
          end
          else if (i_oc_fault && act == ACT_DELAYED)
          begin
            state_reg <= SEQ_DELAY;
            tick_reg <= 3'd0;
          end
        end
        SEQ_DELAY:
        begin
          if (!i_oc_fault)
            state_reg <= SEQ_RUN;
          else if (i_pwm_tick && tick_reg + 3'd1 >= dly_ticks)
          begin
            state_reg <= give_up ? SEQ_LATCH : SEQ_WAIT;
            rise_reg <= 24'h000000;
            mult_reg <= 3'd0;
          end
          else if (i_pwm_tick)
            tick_reg <= tick_reg + 3'd1;
        end
        SEQ_WAIT:
        begin
          // output off for the restart_wait_period period
          rise_reg <= rise_done ? 24'h000000 : rise_reg + 24'h000001;
          if (rise_done)
          begin
            if (mult_reg + 3'd1 >= restart_wait_period_mult)
            begin
              state_reg <= SEQ_START;
              if (retry != RETRY_FOREVER)
                tries_reg <= tries_reg + 3'd1;
            end
            else
              mult_reg <= mult_reg + 3'd1;
          end
        end
        SEQ_LATCH:
          state_reg <= SEQ_LATCH;
        default:
          state_reg <= SEQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_fault_event <= 1'b0;
      o_power_en <= 1'b0;
      o_latched <= 1'b0;
    end
    else
    begin
      o_fault_event <= fault_rise && (state_reg == SEQ_RUN || state_reg == SEQ_START);
      o_power_en <= (state_reg == SEQ_START) || (state_reg == SEQ_RUN) || (state_reg == SEQ_DELAY);
      o_latched <= (state_reg == SEQ_LATCH);
    end
  end

endmodule : ocf_retry_seq
`default_nettype wire

// file: testbench/ocf_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ocf_top_monitor (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire ocf_pkg::ocf_cmd_s i_cmd,
  input wire logic i_on_cmd,
  input wire logic i_oc_fault,
  input wire logic [31:0] i_phase_current,
  input wire logic signed [15:0] i_die_temp,
  input wire ocf_pkg::ocf_status_s o_status,
  input wire logic o_alert,
  input wire logic [3:0] o_phase_warn,
  input wire logic o_ot_fault,
  input wire logic o_power_en,
  input wire logic o_latched_off
);
  import ocf_pkg::*;
  logic [7:0] act_reg;
  logic [15:0] ot_reg;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ----
  // shadow settings
  // ----
  // action byte as last written
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      act_reg <= OC_ACTION_RST;
    else if (i_cmd.wr && i_cmd.code == CMD_OC_ACTION)
      act_reg <= i_cmd.data[7:0];
  end
  // temperature limit, plain positive words only
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      ot_reg <= {OT_EXP_RST, OT_MANT_RST};
    else if (i_cmd.wr && i_cmd.code == CMD_OT_LIMIT && i_cmd.data[15:10] == 6'h00)
      ot_reg <= i_cmd.data;
  end
  // ----
  // properties
  // ----
  sequence s_fault_hit;
    $rose(i_oc_fault) && o_power_en;
  endsequence
  sequence s_fault_flags;
    o_status.byte_iout_oc && o_status.iout_ocf && o_status.word_iout && o_alert;
  endsequence
  sequence s_warn_flags;
    o_status.iout_ocw && o_status.word_iout && o_status.byte_none_above && o_alert;
  endsequence
  property p_fault_flags;
    s_fault_hit |-> ##3 s_fault_flags;
  endproperty
  property p_imm_off;
    s_fault_hit ##0 (act_reg[7:6] == ACT_IMMEDIATE) |-> ##[1:3] !o_power_en;
  endproperty
  property p_latch;
    s_fault_hit ##0 (act_reg[7:6] == ACT_IMMEDIATE && act_reg[5:3] == RETRY_NONE) |-> ##[1:4] o_latched_off;
  endproperty
  property p_ignore;
    !act_reg[ACT_MSB] && i_on_cmd && o_power_en |=> o_power_en;
  endproperty
  property p_bad_phase;
    i_cmd.wr && i_cmd.code == CMD_OC_WARN && i_cmd.phase inside {[8'h04:8'hfe]} |-> ##2 o_status.cml_invalid && o_alert;
  endproperty
  property p_warn_flags;
    (o_phase_warn & ~$past(o_phase_warn)) != 4'h0 |-> ##2 s_warn_flags;
  endproperty
  property p_warn_max;
    i_phase_current[15:8] >= 8'hf8 |=> o_phase_warn[1];
  endproperty
  property p_warn_floor;
    i_phase_current[7:0] < 8'h20 |=> !o_phase_warn[0];
  endproperty
  property p_ot_high;
    ot_reg != OT_DISABLE_C && i_die_temp >= $signed(ot_reg) |=> o_ot_fault;
  endproperty
  property p_ot_low;
    i_die_temp < $signed(ot_reg) |=> !o_ot_fault;
  endproperty
  a_fault_flags: assert property (p_fault_flags)
    else $error("fault flags missing");
  a_imm_off: assert property (p_imm_off)
    else $error("no immediate shutdown");
  a_latch: assert property (p_latch)
    else $error("no latch off");
  a_ignore: assert property (p_ignore)
    else $error("ignored fault stopped output");
  a_bad_phase: assert property (p_bad_phase)
    else $error("bad phase not flagged");
  a_warn_flags: assert property (p_warn_flags)
    else $error("warning flags missing");
  a_warn_max: assert property (p_warn_max)
    else $error("threshold above top step");
  a_warn_floor: assert property (p_warn_floor)
    else $error("threshold below floor");
  a_ot_high: assert property (p_ot_high)
    else $error("temperature fault missing");
  a_ot_low: assert property (p_ot_low)
    else $error("false temperature fault");
endmodule : ocf_top_monitor
`default_nettype wire

// file: testbench/ocf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ocf_host_model (
  input wire logic i_clk,
  input wire logic [15:0] i_rd_data,
  input wire logic i_rd_valid,
  output var ocf_pkg::ocf_cmd_s o_cmd
);
  import ocf_pkg::*;
  // one command, held across exactly one taking edge
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] phase, input logic [15:0] data,
      output logic [15:0] rdata, output logic rvalid);
    @(negedge i_clk);
    o_cmd = {wr, !wr, code, phase, data};
    @(negedge i_clk);
    rdata = i_rd_data;
    rvalid = i_rd_valid;
    // idle bus shows scrambled fields, never the last command
    o_cmd = {2'b00, ~code, ~phase, ~data};
  endtask : xfer
  initial o_cmd = '0;
endmodule : ocf_host_model
`default_nettype wire

// file: testbench/tb_overcurrent_fault_response_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_overcurrent_fault_response_ctrl;
  import ocf_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clear = 1'b0;
  logic fault = 1'b0;
  logic pwm_tick = 1'b0;
  logic on_cmd = 1'b1;
  logic restore = 1'b0;
  logic start_ok = 1'b0;
  logic [1:0] tick_cnt = 2'h0;
  logic [31:0] cur = 32'h0000_0000;
  logic signed [15:0] temp = 16'h0019;
  ocf_cmd_s cmd;
  ocf_status_s status;
  logic [15:0] rd_data;
  logic [15:0] rdat;
  logic [3:0] warn;
  logic rd_valid, alert, ot_fault, power_en, latched, rval;
  int errors = 0;
  int compares = 0;
  int n;
  ocf_top uut (.i_clk(clk), .i_sys_rst(sys_rst), .i_cmd(cmd), .i_clear_faults(clear), .i_nvm_restore(restore),
    .i_num_phases(3'h2), .i_oc_fault(fault), .i_pwm_tick(pwm_tick), .i_rise_cycles(24'h00_0014),
    .i_on_cmd(on_cmd), .i_startup_ok(start_ok), .i_phase_current(cur), .i_die_temp(temp),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_status(status), .o_alert(alert), .o_phase_warn(warn),
    .o_ot_fault(ot_fault), .o_power_en(power_en), .o_latched_off(latched));
  ocf_host_model host (.i_clk(clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid), .o_cmd(cmd));
  // clock and a switching tick every fourth cycle
  always #4 clk = ~clk;
  always @(negedge clk)
  begin
    tick_cnt <= tick_cnt + 2'h1;
    pwm_tick <= (tick_cnt == 2'h3);
  end
  // ----
  // helpers
  // ----
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] code, input logic [7:0] ph, input logic [15:0] d);
    host.xfer(1'b1, code, ph, d, rdat, rval);
  endtask : wr
  task automatic rd_chk(input logic [7:0] code, input logic [7:0] ph, input logic [15:0] exp, input string what);
    host.xfer(1'b0, code, ph, 16'h0000, rdat, rval);
    cmp({15'h0000, rval}, 16'h0001, "read valid");
    cmp(rdat, exp, what);
  endtask : rd_chk
  task automatic warn_chk(input logic [7:0] ph1, input logic [7:0] ph0, input logic [3:0] exp);
    cur = {16'h0000, ph1, ph0};
    cyc(2);
    cmp({12'h000, warn}, {12'h000, exp}, "phase warn");
  endtask : warn_chk
  task automatic clr();
    clear = 1'b1;
    cyc(1);
    clear = 1'b0;
    cyc(1);
  endtask : clr
  task automatic wait_pwr(input logic lvl, output int k);
    k = 0;
    while (power_en !== lvl && k < 200)
    begin
      @(negedge clk);
      k++;
    end
    cmp({15'h0000, power_en}, {15'h0000, lvl}, "power level");
  endtask : wait_pwr
  task automatic cycle_on();
    on_cmd = 1'b0;
    cyc(3);
    on_cmd = 1'b1;
    wait_pwr(1'b1, n);
  endtask : cycle_on
  // ----
  // scenarios
  // ----
  task automatic t_reset_values();
    rd_chk(CMD_OC_ACTION, 8'h00, {8'h00, OC_ACTION_RST}, "action reset");
    rd_chk(CMD_OC_WARN, 8'h00, {5'b11110, WARN_MANT_RST}, "warn reset");
    rd_chk(CMD_OT_LIMIT, 8'h00, {OT_EXP_RST, OT_MANT_RST}, "temp reset");
  endtask : t_reset_values
  task automatic t_warn();
    wr(CMD_OC_WARN, 8'h00, 16'hf0fc);
    cyc(1);
    cmp({15'h0000, status.cml_invalid & alert}, 16'h0001, "invalid flag");
    rd_chk(CMD_OC_WARN, 8'h00, {5'b11110, WARN_MANT_RST}, "refused kept");
    clr();
    wr(CMD_OC_WARN, 8'h05, 16'hf050);
    cyc(2);
    clr();
    wr(CMD_OC_WARN, 8'h00, 16'hf010);
    rd_chk(CMD_OC_WARN, 8'h00, 16'hf010, "low limit kept");
    wr(CMD_OC_WARN, 8'h01, 16'hf024);
    warn_chk(8'h27, 8'h1f, 4'h0);
    warn_chk(8'h28, 8'h20, 4'h3);
    cyc(2);
    cmp({12'h000, status.iout_ocw, status.word_iout, status.byte_none_above, alert}, 16'h000f, "warn flags");
    warn_chk(8'hf8, 8'h00, 4'h2);
    warn_chk(8'h00, 8'h00, 4'h0);
    clr();
  endtask : t_warn
  task automatic t_all_phase();
    wr(CMD_OC_WARN, PHASE_ALL, 16'hf1f4);
    cmp({15'h0000, status.cml_invalid}, 16'h0001, "stack limit");
    wr(CMD_OC_WARN, PHASE_ALL, 16'hf0a0);
    rd_chk(CMD_OC_WARN, 8'h00, 16'hf050, "phase 0 share");
    rd_chk(CMD_OC_WARN, 8'h01, 16'hf050, "phase 1 share");
    rd_chk(CMD_OC_WARN, PHASE_ALL, 16'hf0a0, "stack read");
    wr(CMD_OC_WARN, 8'h00, 16'he035);
    restore = 1'b1;
    cyc(1);
    restore = 1'b0;
    rd_chk(CMD_OC_WARN, 8'h00, 16'hf00d, "restored");
  endtask : t_all_phase
  task automatic t_ot();
    wr(CMD_OT_LIMIT, 8'h00, 16'h0032);
    temp = 16'h0032;
    cyc(2);
    cmp({15'h0000, ot_fault}, 16'h0001, "at limit");
    temp = 16'h0031;
    cyc(2);
    cmp({15'h0000, ot_fault}, 16'h0000, "below limit");
  endtask : t_ot
  task automatic t_ignore();
    for (int i = 0; i < 2; i++)
    begin
      wr(CMD_OC_ACTION, 8'h00, {8'h00, i[1:0], 6'h09});
      clr();
      fault = 1'b1;
      cyc(6);
      cmp({14'h0000, power_en, status.iout_ocf}, 16'h0003, "ignored fault");
      fault = 1'b0;
      cyc(2);
    end
  endtask : t_ignore
  task automatic t_retry();
    wr(CMD_OC_ACTION, 8'h00, 16'h00c9);
    clr();
    fault = 1'b1;
    cyc(3);
    cmp({13'h0000, power_en, status.byte_iout_oc & status.iout_ocf & status.word_iout, alert}, 16'h0003, "oc off");
    fault = 1'b0;
    wait_pwr(1'b1, n);
    cmp({15'h0000, n >= 15 && n <= 24}, 16'h0001, "one rise wait");
    fault = 1'b1;
    cyc(5);
    fault = 1'b0;
    cyc(30);
    cmp({14'h0000, power_en, latched}, 16'h0001, "retries spent");
    cycle_on();
    cmp({15'h0000, latched}, 16'h0000, "latch cleared");
    fault = 1'b1;
    cyc(3);
    fault = 1'b0;
    wait_pwr(1'b1, n);
    cmp({14'h0000, power_en, latched}, 16'h0002, "fresh retry");
  endtask : t_retry
  task automatic t_latch0();
    wr(CMD_OC_ACTION, 8'h00, 16'h00c1);
    fault = 1'b1;
    cyc(5);
    fault = 1'b0;
    cyc(30);
    cmp({14'h0000, power_en, latched}, 16'h0001, "no restart");
    cycle_on();
  endtask : t_latch0
  task automatic t_delay();
    wr(CMD_OC_ACTION, 8'h00, 16'h0092);
    fault = 1'b1;
    cyc(4);
    cmp({15'h0000, power_en}, 16'h0001, "still running");
    wait_pwr(1'b0, n);
    cmp({15'h0000, n <= 16}, 16'h0001, "three ticks");
    fault = 1'b0;
    wait_pwr(1'b1, n);
    cmp({15'h0000, n >= 35 && n <= 48}, 16'h0001, "two rises wait");
  endtask : t_delay
  task automatic t_startup();
    wr(CMD_OC_ACTION, 8'h00, 16'h00c9);
    start_ok = 1'b1;
    cyc(1);
    start_ok = 1'b0;
    fault = 1'b1;
    cyc(2);
    fault = 1'b0;
    wait_pwr(1'b1, n);
    cmp({14'h0000, power_en, latched}, 16'h0002, "allowance renewed");
  endtask : t_startup
  task automatic t_forever();
    wr(CMD_OC_ACTION, 8'h00, 16'h00bd);
    fault = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      wait_pwr(1'b0, n);
      cmp({15'h0000, n >= 24 && n <= 32}, 16'h0001, "seven ticks");
      wait_pwr(1'b1, n);
      cmp({15'h0000, n >= 96 && n <= 104}, 16'h0001, "five rises");
    end
    cmp({15'h0000, latched}, 16'h0000, "endless retry");
    fault = 1'b0;
  endtask : t_forever
  // ----
  // verdict
  // ----
  task automatic test_done();
    if (errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    cyc(4);
    t_reset_values();
    t_warn();
    t_all_phase();
    t_ot();
    t_ignore();
    t_retry();
    t_latch0();
    t_delay();
    t_startup();
    t_forever();
    test_done();
  end
  // watchdog against a hung handshake
  initial
  begin
    #100000;
    errors++;
    test_done();
  end
endmodule : tb_overcurrent_fault_response_ctrl
bind ocf_top ocf_top_monitor u_mon (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cmd(i_cmd), .i_on_cmd(i_on_cmd),
  .i_oc_fault(i_oc_fault), .i_phase_current(i_phase_current), .i_die_temp(i_die_temp), .o_status(o_status),
  .o_alert(o_alert), .o_phase_warn(o_phase_warn), .o_ot_fault(o_ot_fault), .o_power_en(o_power_en),
  .o_latched_off(o_latched_off));
`default_nettype wire
